// ==== logic/pirq_core.sv ====
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "pirq_params.svh"

// Functional notes
// - Event flags set whatever the individual, group or global enables hold.
// - Converter-done flag at bit 6 sets on conversion end, sticky until cleared.
// - Without a converter the converter-done flag is absent and reads zero.
// - Receive flag bit 5 marks buffered data, cleared only by reading receive data.
// - Transmit flag bit 4 marks empty buffer, cleared only by writing transmit data.
// - Sync serial flag bit 3 sets when a transfer finishes, sticky.
// - Capture/compare flag bit 2 sets on capture or match, never in PWM.
// - Timer-two flag bit 1 sets on period match, sticky.
// - Timer-one flag bit 0 sets on count overflow, sticky.
// - Second enable register holds bits 7, 6, 4; others read zero.
// - Oscillator-fail flag bit 7 sets on clock failover, sticky.
// - Comparator flag bit 6 sets on any comparator change, sticky.
// - Nonvolatile-write flag bit 4 sets when a write completes, sticky.
// - Second flag register bits 5 and 3..0 read zero.
// - Power-on status bit 1 clears on power-on reset until software sets it.
// - Brown-out status bit 0 clears on brown-out reset until software sets it.
// - Brown-out bit reads zero after power-on; meaningless with detection disabled.
// - Reset-cause bits 7..2 read zero.
// - No peripheral interrupt without the peripheral-group enable.
// - First enable register mirrors first flag register bit positions.
module pirq_core #(
    parameter bit HAS_CONVERTER = 1'b1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire pirq_pkg::pirq_bus_req_s busReq,
    output logic [7:0] rdData,
    input wire pirq_pkg::pirq_events_s ev,
    input wire pirq_pkg::pirq_ccp_mode_e ccpMode,
    input wire logic [1:0] compOut,
    input wire logic brownoutDetectEnable,
    input wire logic [7:0] rxData,
    output logic rxDataRead,
    output logic [7:0] txData,
    output logic txDataWrite,
    output logic periphIrq
);
    localparam logic [7:0] CONV_MASK = HAS_CONVERTER ? 8'h40 : 8'h00;
    localparam logic [7:0] ONE_MASK = `PIRQ_MASK_ONE & ~(8'h40 & ~CONV_MASK);
    localparam logic [7:0] ONE_SW_MASK = `PIRQ_MASK_ONE_SW & ONE_MASK;

    pirq_pkg::pirq_state_s st_q;
    pirq_pkg::pirq_state_s st_d;

    logic [15:0] flagSet;
    logic [15:0] flagClr;
    logic [15:0] flags;
    logic [7:0] flagsOne;
    logic [7:0] flagsTwo;
    logic [7:0] evOne;
    logic [7:0] evTwo;
    logic wrOne;
    logic wrTwo;
    logic rxRd;
    logic txWr;
    logic compChange;

    function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
        hit = strobe && (addr == target);
    endfunction

    assign wrOne = hit(busReq.wr, busReq.addr, `PIRQ_ADDR_FLAGS_ONE);
    assign wrTwo = hit(busReq.wr, busReq.addr, `PIRQ_ADDR_FLAGS_TWO);
    assign rxRd = hit(busReq.rd, busReq.addr, `PIRQ_ADDR_RX_DATA);
    assign txWr = hit(busReq.wr, busReq.addr, `PIRQ_ADDR_TX_DATA);

    // Comparator outputs are treated as asynchronous, so edges come from the second stage
    assign compChange = st_q.compValid && (st_q.compSync != st_q.compPrev);

    always_comb begin
        evOne = 8'h00;
        evOne[`PIRQ_BIT_CONV] = ev.convDone & CONV_MASK[`PIRQ_BIT_CONV];
        evOne[`PIRQ_BIT_RX] = ev.rxLoad;
        evOne[`PIRQ_BIT_TX] = ev.txDrain;
        evOne[`PIRQ_BIT_SYNC] = ev.syncDone;
        evOne[`PIRQ_BIT_CCP] = ((ccpMode == pirq_pkg::PIRQ_CCP_CAPTURE) && ev.ccpCapture)
            || ((ccpMode == pirq_pkg::PIRQ_CCP_COMPARE) && ev.ccpMatch);
        evOne[`PIRQ_BIT_T2] = ev.timerTwoMatch;
        evOne[`PIRQ_BIT_T1] = ev.timerOneOverflow;
        evTwo = 8'h00;
        evTwo[`PIRQ_BIT_OSC] = ev.oscFail;
        evTwo[`PIRQ_BIT_CMP] = compChange;
        evTwo[`PIRQ_BIT_NV] = ev.nvWriteDone;
    end

    always_comb begin
        flagSet[7:0] = evOne | ({8{wrOne}} & busReq.wdata & ONE_SW_MASK);
        flagSet[15:8] = evTwo | ({8{wrTwo}} & busReq.wdata & `PIRQ_MASK_TWO);
        flagClr[7:0] = {8{wrOne}} & ~busReq.wdata & ONE_SW_MASK;
        flagClr[`PIRQ_BIT_RX] = rxRd;
        flagClr[`PIRQ_BIT_TX] = txWr;
        flagClr[15:8] = {8{wrTwo}} & ~busReq.wdata & `PIRQ_MASK_TWO;
    end

    pirq_flag_bank #(
        .W(16)
    ) u_flags (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .setEv(flagSet),
        .clrEv(flagClr),
        .flags(flags)
    );

    // Masking on the way out keeps absent bits at zero even if a set slipped in
    assign flagsOne = flags[7:0] & ONE_MASK;
    assign flagsTwo = flags[15:8] & `PIRQ_MASK_TWO;

    always_comb begin
        st_d = st_q;
        st_d.compMeta = compOut;
        st_d.compSync = st_q.compMeta;
        st_d.compPrev = st_q.compSync;
        st_d.compValid = 1'b1;
        st_d.rxRead = rxRd;
        st_d.txWrite = txWr;
        if (txWr) begin
            st_d.txData = busReq.wdata;
        end
        if (busReq.wr) begin
            unique case (busReq.addr)
                `PIRQ_ADDR_IRQ_CTL: begin
                    st_d.global_irq_enable = busReq.wdata[`PIRQ_BIT_GIE];
                    st_d.peripheral_group_enable = busReq.wdata[`PIRQ_BIT_PERIPHERAL_GROUP_ENABLE];
                end
                `PIRQ_ADDR_ENABLES_ONE: begin
                    st_d.enOne = busReq.wdata & ONE_MASK;
                end
                `PIRQ_ADDR_ENABLES_TWO: begin
                    st_d.enTwo = busReq.wdata & `PIRQ_MASK_TWO;
                end
                `PIRQ_ADDR_RESET_CAUSE: begin
                    st_d.por = busReq.wdata[`PIRQ_BIT_POR];
                    st_d.bor = busReq.wdata[`PIRQ_BIT_BOR];
                end
                default: begin
                end
            endcase
        end
        // Hardware evidence of a brown-out outranks a software set in the same cycle
        if (ev.brownout && brownoutDetectEnable) begin
            st_d.bor = 1'b0;
        end
        st_d.rdata = `PIRQ_RST_BYTE;
        if (busReq.rd) begin
            unique case (busReq.addr)
                `PIRQ_ADDR_IRQ_CTL: st_d.rdata = {st_q.global_irq_enable, st_q.peripheral_group_enable, 6'h00};
                `PIRQ_ADDR_FLAGS_ONE: st_d.rdata = flagsOne;
                `PIRQ_ADDR_FLAGS_TWO: st_d.rdata = flagsTwo;
                `PIRQ_ADDR_ENABLES_ONE: st_d.rdata = st_q.enOne;
                `PIRQ_ADDR_ENABLES_TWO: st_d.rdata = st_q.enTwo;
                `PIRQ_ADDR_RESET_CAUSE: st_d.rdata = {6'h00, st_q.por, st_q.bor};
                `PIRQ_ADDR_RX_DATA: st_d.rdata = rxData;
                default: st_d.rdata = `PIRQ_RST_BYTE;
            endcase
        end
        st_d.irq = st_q.global_irq_enable && st_q.peripheral_group_enable
            && (|(flagsOne & st_q.enOne) || |(flagsTwo & st_q.enTwo));
    end

    // Power-on is the asynchronous reset; the brown-out bit has no defined meaning here
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdData = st_q.rdata;
    assign rxDataRead = st_q.rxRead;
    assign txDataWrite = st_q.txWrite;
    assign txData = st_q.txData;
    assign periphIrq = st_q.irq;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_timer_one_set: assert property (ev.timerOneOverflow |=> flagsOne[`PIRQ_BIT_T1]
        ##1 (flagsOne[`PIRQ_BIT_T1] || $past(wrOne)))
        else $error("timer-one flag not set and held");

    a_flag_sticky: assert property ((flagsOne[`PIRQ_BIT_T2] && !wrOne) |=> flagsOne[`PIRQ_BIT_T2])
        else $error("timer-two flag dropped without software clear");

    a_conv_absent: assert property (!HAS_CONVERTER |-> !flagsOne[`PIRQ_BIT_CONV])
        else $error("converter flag present on converterless variant");

    a_rx_read_clear: assert property ((rxRd && !ev.rxLoad) |=> !flagsOne[`PIRQ_BIT_RX] && rxDataRead)
        else $error("receive flag not cleared by data read");

    a_rx_write_ignored: assert property ((flagsOne[`PIRQ_BIT_RX] && !rxRd) |=> flagsOne[`PIRQ_BIT_RX])
        else $error("receive flag cleared without data read");

    a_tx_write_clear: assert property ((txWr && !ev.txDrain) |=> !flagsOne[`PIRQ_BIT_TX] && txDataWrite)
        else $error("transmit flag not cleared by data write");

    a_ccp_pwm_quiet: assert property ($rose(flagsOne[`PIRQ_BIT_CCP])
        |-> $past(ccpMode) != pirq_pkg::PIRQ_CCP_PWM || $past(wrOne))
        else $error("capture/compare flag set in pwm mode");

    a_two_unused_zero: assert property (busReq.rd && busReq.addr == `PIRQ_ADDR_FLAGS_TWO
        |=> (rdData & ~`PIRQ_MASK_TWO) == 8'h00)
        else $error("second flag register unused bits nonzero");

    a_cause_upper_zero: assert property (busReq.rd && busReq.addr == `PIRQ_ADDR_RESET_CAUSE
        |=> rdData[7:2] == 6'h00)
        else $error("reset-cause upper bits nonzero");

    a_bor_cleared: assert property (ev.brownout && brownoutDetectEnable |=> !st_q.bor [*1])
        else $error("brown-out status not cleared");

    a_irq_needs_group: assert property (periphIrq |-> $past(st_q.peripheral_group_enable) && $past(st_q.global_irq_enable))
        else $error("interrupt without group and global enable");

    a_irq_raised: assert property ((st_q.global_irq_enable && st_q.peripheral_group_enable
        && (|(flagsOne & st_q.enOne) || |(flagsTwo & st_q.enTwo))) |=> periphIrq)
        else $error("interrupt not raised for enabled flag");

    a_set_unmasked: assert property ((ev.nvWriteDone && !st_q.enTwo[`PIRQ_BIT_NV]) |=> flagsTwo[`PIRQ_BIT_NV])
        else $error("masked event did not set its flag");
endmodule

// ==== logic/pirq_flag_bank.sv ====
`timescale 1ns/1ps
`include "pirq_params.svh"

// Sticky flags: a set in the same cycle as a clear wins
module pirq_flag_bank #(
    parameter int W = 16
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] setEv,
    input wire logic [W-1:0] clrEv,
    output logic [W-1:0] flags
);
    typedef struct packed {
        logic [W-1:0] flags;
    } pirq_bank_s;

    pirq_bank_s st_q;
    pirq_bank_s st_d;

    always_comb begin
        st_d = st_q;
        st_d.flags = setEv | (st_q.flags & ~clrEv);
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flags = st_q.flags;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_set_wins_clear: assert property (|(setEv & clrEv) |=> ((flags & $past(setEv)) == $past(setEv)))
        else $error("set lost against same-cycle clear");
endmodule

// ==== logic/pirq_params.svh ====
`ifndef PIRQ_PARAMS_SVH
`define PIRQ_PARAMS_SVH

// Register addresses
`define PIRQ_ADDR_IRQ_CTL 8'h0b
`define PIRQ_ADDR_FLAGS_ONE 8'h0c
`define PIRQ_ADDR_FLAGS_TWO 8'h0d
`define PIRQ_ADDR_ENABLES_ONE 8'h8c
`define PIRQ_ADDR_ENABLES_TWO 8'h8d
`define PIRQ_ADDR_RESET_CAUSE 8'h8e
`define PIRQ_ADDR_RX_DATA 8'h1a
`define PIRQ_ADDR_TX_DATA 8'h19

// Field positions
`define PIRQ_BIT_CONV 6
`define PIRQ_BIT_RX 5
`define PIRQ_BIT_TX 4
`define PIRQ_BIT_SYNC 3
`define PIRQ_BIT_CCP 2
`define PIRQ_BIT_T2 1
`define PIRQ_BIT_T1 0
`define PIRQ_BIT_OSC 7
`define PIRQ_BIT_CMP 6
`define PIRQ_BIT_NV 4
`define PIRQ_BIT_POR 1
`define PIRQ_BIT_BOR 0
`define PIRQ_BIT_GIE 7
`define PIRQ_BIT_PERIPHERAL_GROUP_ENABLE 6

// Implemented and software-writable masks
`define PIRQ_MASK_ONE 8'h7f
`define PIRQ_MASK_ONE_SW 8'h4f
`define PIRQ_MASK_TWO 8'hd0
`define PIRQ_MASK_CTL 8'hc0
`define PIRQ_MASK_CAUSE 8'h03

// Reset values
`define PIRQ_RST_FLAGS 16'h0000
`define PIRQ_RST_BYTE 8'h00

`endif

// ==== logic/pirq_pkg.sv ====
package pirq_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pirq_bus_req_s;

    typedef struct packed {
        logic convDone;
        logic rxLoad;
        logic txDrain;
        logic syncDone;
        logic ccpCapture;
        logic ccpMatch;
        logic timerTwoMatch;
        logic timerOneOverflow;
        logic oscFail;
        logic nvWriteDone;
        logic brownout;
    } pirq_events_s;

    typedef enum logic [1:0] {
        PIRQ_CCP_OFF = 2'h0,
        PIRQ_CCP_CAPTURE = 2'h1,
        PIRQ_CCP_COMPARE = 2'h2,
        PIRQ_CCP_PWM = 2'h3
    } pirq_ccp_mode_e;

    typedef struct packed {
        logic [7:0] enOne;
        logic [7:0] enTwo;
        logic global_irq_enable;
        logic peripheral_group_enable;
        logic por;
        logic bor;
        logic [1:0] compMeta;
        logic [1:0] compSync;
        logic [1:0] compPrev;
        logic compValid;
        logic [7:0] rdata;
        logic irq;
        logic rxRead;
        logic txWrite;
        logic [7:0] txData;
    } pirq_state_s;

endpackage

// ==== sim/pirq_core_test.sv ====
`timescale 1ns/1ps
`include "pirq_params.svh"

module pirq_core_test;
    logic sys_clk;
    logic sys_rst;
    pirq_pkg::pirq_bus_req_s busReq;
    pirq_pkg::pirq_events_s evReq;
    pirq_pkg::pirq_events_s ev;
    pirq_pkg::pirq_ccp_mode_e ccpMode;
    logic compFlip;
    logic brownoutDetectEnable;
    logic periphIrq, rxDataRead, txDataWrite;
    logic rdPend = 1'b0;
    logic [1:0] compOut;
    logic [7:0] rdData, rdDataNc, rxData, txData, pendAddr, txByte, rxByte;
    logic [7:0] expQ[$];
    string nameQ[$];
    int failures = 0;
    int checksDone = 0;
    int cycles = 0;

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    pirq_event_src pirq_event_src_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .evReq(evReq), .compFlip(compFlip),
        .ev(ev), .compOut(compOut));
    pirq_core pirq_core_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .busReq(busReq), .rdData(rdData), .ev(ev),
        .ccpMode(ccpMode), .compOut(compOut), .brownoutDetectEnable(brownoutDetectEnable), .rxData(rxData),
        .rxDataRead(rxDataRead), .txData(txData), .txDataWrite(txDataWrite), .periphIrq(periphIrq));
    // Variant without converter shares all stimulus
    pirq_core #(.HAS_CONVERTER(1'b0)) pirq_core_nc_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .busReq(busReq),
        .rdData(rdDataNc), .ev(ev), .ccpMode(ccpMode), .compOut(compOut),
        .brownoutDetectEnable(brownoutDetectEnable), .rxData(rxData), .rxDataRead(), .txData(), .txDataWrite(),
        .periphIrq());

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checksDone++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("Counts: %0d checks, %0d failures", checksDone, failures);
        if (failures == 0 && checksDone > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        busReq.wr <= 1'b0;
    endtask

    // Expected value is queued; the monitor pops it when the data appear
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge sys_clk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        expQ.push_back(e);
        nameQ.push_back(n);
        @(posedge sys_clk);
        busReq.rd <= 1'b0;
    endtask

    // Waits long enough for the resynchronised comparator too
    task automatic fire(input logic [10:0] e, input logic flip);
        @(posedge sys_clk);
        evReq <= pirq_pkg::pirq_events_s'(e);
        compFlip <= flip;
        @(posedge sys_clk);
        evReq <= '0;
        compFlip <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic irqIs(input logic e);
        repeat (4) @(posedge sys_clk);
        check("periphIrq", {7'h0, e}, {7'h0, periphIrq});
    endtask

    // Read data stand only in the cycle after the strobe
    always @(negedge sys_clk) begin
        if (rdPend) begin
            check(nameQ.pop_front(), expQ.pop_front(), rdData);
            if (pendAddr == `PIRQ_ADDR_FLAGS_ONE || pendAddr == `PIRQ_ADDR_ENABLES_ONE) begin
                check("no converter bit", 8'h00, {7'h0, rdDataNc[6]});
            end
            if (pendAddr == `PIRQ_ADDR_RX_DATA) begin
                check("rxDataRead", 8'h01, {7'h0, rxDataRead});
            end
        end
        rdPend = busReq.rd;
        pendAddr = busReq.addr;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            $display("Timeout after %0d cycles", cycles);
            summarize();
        end
    end

    initial begin
        sys_rst = 1'b1;
        busReq = '0;
        evReq = '0;
        ccpMode = pirq_pkg::PIRQ_CCP_PWM;
        compFlip = 1'b0;
        brownoutDetectEnable = 1'b0;
        rxData = 8'h00;
        void'($urandom(32'h5354_236d));
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(8'h0b + 8'(i / 3) * 8'h81 + 8'(i % 3), 8'h00, "reset value");
        end
        rd(8'h55, 8'h00, "unmapped");
        $display("Test reset finished");
        fire(11'h060, 1'b0);
        rd(`PIRQ_ADDR_FLAGS_ONE, 8'h00, "pwm ignored");
        ccpMode <= pirq_pkg::PIRQ_CCP_CAPTURE;
        fire(11'h040, 1'b0);
        rd(`PIRQ_ADDR_FLAGS_ONE, 8'h04, "capture");
        wr(`PIRQ_ADDR_FLAGS_ONE, 8'h00);
        ccpMode <= pirq_pkg::PIRQ_CCP_COMPARE;
        fire(11'h020, 1'b0);
        rd(`PIRQ_ADDR_FLAGS_ONE, 8'h04, "compare");
        fire(11'h798, 1'b0);
        rd(`PIRQ_ADDR_FLAGS_ONE, 8'h7f, "all events");
        wr(`PIRQ_ADDR_FLAGS_ONE, 8'h00);
        rd(`PIRQ_ADDR_FLAGS_ONE, 8'h30, "sticky clear");
        // Expected byte kept apart: the input only takes the new value after this time step
        rxByte = 8'($urandom());
        rxData <= rxByte;
        txByte = 8'($urandom());
        rd(`PIRQ_ADDR_RX_DATA, rxByte, "rx data");
        rd(`PIRQ_ADDR_FLAGS_ONE, 8'h10, "rx cleared");
        wr(`PIRQ_ADDR_TX_DATA, txByte);
        @(negedge sys_clk);
        check("txDataWrite", 8'h01, {7'h0, txDataWrite});
        rd(`PIRQ_ADDR_FLAGS_ONE, 8'h00, "tx cleared");
        check("txData", txByte, txData);
        // Event reaches the core in the same cycle as a software clear
        @(posedge sys_clk);
        evReq <= pirq_pkg::pirq_events_s'(11'h008);
        @(posedge sys_clk);
        evReq <= '0;
        busReq <= '{addr: `PIRQ_ADDR_FLAGS_ONE, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        busReq.wr <= 1'b0;
        rd(`PIRQ_ADDR_FLAGS_ONE, 8'h01, "set beats clear");
        $display("Test flags one finished");
        fire(11'h006, 1'b1);
        rd(`PIRQ_ADDR_FLAGS_TWO, 8'hd0, "flags two events");
        wr(`PIRQ_ADDR_FLAGS_TWO, 8'h00);
        rd(`PIRQ_ADDR_FLAGS_TWO, 8'h00, "flags two clear");
        wr(`PIRQ_ADDR_FLAGS_TWO, 8'hff);
        rd(`PIRQ_ADDR_FLAGS_TWO, 8'hd0, "flags two unused");
        wr(`PIRQ_ADDR_ENABLES_TWO, 8'hff);
        rd(`PIRQ_ADDR_ENABLES_TWO, 8'hd0, "enables two");
        wr(`PIRQ_ADDR_ENABLES_ONE, 8'hff);
        rd(`PIRQ_ADDR_ENABLES_ONE, 8'h7f, "enables one");
        $display("Test flags two finished");
        wr(`PIRQ_ADDR_FLAGS_TWO, 8'h00);
        wr(`PIRQ_ADDR_ENABLES_ONE, 8'h01);
        wr(`PIRQ_ADDR_IRQ_CTL, 8'h80);
        fire(11'h008, 1'b0);
        irqIs(1'b0);
        wr(`PIRQ_ADDR_IRQ_CTL, 8'hff);
        irqIs(1'b1);
        rd(`PIRQ_ADDR_IRQ_CTL, 8'hc0, "control");
        wr(`PIRQ_ADDR_ENABLES_ONE, 8'h02);
        irqIs(1'b0);
        $display("Test request finished");
        wr(`PIRQ_ADDR_RESET_CAUSE, 8'hff);
        rd(`PIRQ_ADDR_RESET_CAUSE, 8'h03, "cause unused");
        fire(11'h001, 1'b0);
        rd(`PIRQ_ADDR_RESET_CAUSE, 8'h03, "detect off");
        brownoutDetectEnable <= 1'b1;
        fire(11'h001, 1'b0);
        rd(`PIRQ_ADDR_RESET_CAUSE, 8'h02, "brownout");
        // Let the read data stand for the monitor before reset wipes them
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(`PIRQ_ADDR_RESET_CAUSE, 8'h00, "power on");
        rd(`PIRQ_ADDR_FLAGS_ONE, 8'h00, "flags after reset");
        repeat (3) @(posedge sys_clk);
        $display("Test reset cause finished");
        summarize();
    end
endmodule

// ==== sim/pirq_event_src.sv ====
`timescale 1ns/1ps

// Peripheral event sources: each request is registered and reaches the core one cycle later, for as long as it is held
module pirq_event_src (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire pirq_pkg::pirq_events_s evReq,
    input wire logic compFlip,
    output pirq_pkg::pirq_events_s ev,
    output logic [1:0] compOut
);
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ev <= '0;
            compOut <= 2'h0;
        end else begin
            // Strobes come regardless of any enable state
            ev <= evReq;
            // Comparators toggle on request; the core must resynchronise them
            compOut <= compFlip ? ~compOut : compOut;
        end
    end
endmodule
